// ==== rtl/can_filter_pkg.sv ====
// Purpose: Constants for the acceptance filter configuration block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Each filter uses one byte lane of a control register
package can_filter_pkg;
    localparam int unsigned addr_w = 8;
    localparam logic [7:0] off_ctrl_8_11 = 8'h00;
    localparam logic [7:0] off_ctrl_20_23 = 8'h04;
    localparam logic [7:0] off_view = 8'h08;
    localparam int unsigned lanes = 4;
    localparam int unsigned lane_w = 8;
    localparam int unsigned en_bit = 7;
    localparam int unsigned msel_hi = 6;
    localparam int unsigned msel_lo = 5;
    localparam int unsigned fsel_hi = 4;
    localparam int unsigned fsel_lo = 0;
    localparam int unsigned msel_w = 2;
    localparam int unsigned fsel_w = 5;
    localparam logic [7:0] lane_reset = 8'h00;
    localparam logic [31:0] read_zero = 32'h0000_0000;
endpackage

// ==== rtl/filter_lane.sv ====
// Purpose: One filter's enable, mask selector and FIFO selector
// Assumes: Write strobe qualified by the bus slave
// Notes: Selectors locked while the filter is enabled
`timescale 1ns/10ps
module filter_lane
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] lane
);
    logic [7:0] lane_ff;
    logic [7:0] nxt_lane;
    wire logic locked = lane_ff[can_filter_pkg::en_bit];
    // Enable always writable; fields only while disabled
    assign nxt_lane = !wr ? lane_ff :
        locked ? {wdata[can_filter_pkg::en_bit],
                  lane_ff[can_filter_pkg::msel_hi:can_filter_pkg::fsel_lo]}
               : wdata;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            lane_ff <= can_filter_pkg::lane_reset;
        else
            lane_ff <= nxt_lane;
    end
    assign lane = lane_ff;
endmodule

// ==== rtl/can_acceptance_filter_config.sv ====
// Purpose: Register file for two CAN filter control registers
// Assumes: APB master keeps the request stable until pready
// Notes: Zero wait states; unmapped reads return zero with pslverr
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// Function
// - A filter is active only while its enable bit is 1.
// - The two-bit mask selector 00..11 picks mask 0..3.
// - A matching message goes to the FIFO named by the five-bit selector.
// - Mask and FIFO selectors change only while the filter is disabled.
// - Filter 11 has enable at 31, mask at 30-29, FIFO at 28-24.
// - Filter 10 has enable at 23, mask 22-21, FIFO 20-16; 9, 8 below.
// - The register for filters 20-23 uses the same byte-lane layout.
module can_acceptance_filter_config
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] filter_active,
    output logic [15:0] acceptance_mask_select,
    output logic [39:0] target_fifo_select
);
    localparam int unsigned nf = 2 * can_filter_pkg::lanes;
    logic [nf*8-1:0] lanes_all;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic pready_ff;
    logic [7:0] active_ff;
    logic [15:0] msel_ff;
    logic [39:0] fsel_ff;
    logic [7:0] nxt_active;
    logic [15:0] nxt_msel;
    logic [39:0] nxt_fsel;

    wire logic setup = psel && !penable;
    wire logic wr_go = psel && penable && pwrite;
    wire logic hit_a = paddr == can_filter_pkg::off_ctrl_8_11;
    wire logic hit_b = paddr == can_filter_pkg::off_ctrl_20_23;
    wire logic hit_v = paddr == can_filter_pkg::off_view;
    wire logic mapped = hit_a || hit_b || hit_v;
    wire logic [31:0] reg_a = lanes_all[31:0];
    wire logic [31:0] reg_b = lanes_all[63:32];
    // Word 2 is a read-only view of active filters in the low byte
    wire logic [31:0] rd_mux = hit_a ? reg_a :
        hit_b ? reg_b :
        hit_v ? {24'h00_0000, nxt_active} : can_filter_pkg::read_zero;

    // The byte-lane decode below cannot serve any other lane shape
    if (can_filter_pkg::lane_w != 8 || can_filter_pkg::lanes != 4)
    begin : gen_bad_layout
        $error("filter config needs four byte-wide lanes per register");
    end

    // Filters 8..11 in lanes 0..3, filters 20..23 in lanes 4..7
    genvar g;
    generate
        for (g = 0; g < nf; g++)
        begin : gen_lane
            localparam int unsigned ln = g % can_filter_pkg::lanes;
            wire logic hit = (g < can_filter_pkg::lanes) ? hit_a : hit_b;
            filter_lane u_lane
            (
                .clk(clk),
                .rst_b(rst_b),
                .wr(wr_go && hit && pstrb[ln]),
                .wdata(pwdata[ln*8 +: 8]),
                .lane(lanes_all[g*8 +: 8])
            );
            // Disabled filters present zero selectors downstream
            assign nxt_active[g] = lanes_all[g*8+can_filter_pkg::en_bit];
            assign nxt_msel[g*2 +: 2] = nxt_active[g] ?
                lanes_all[g*8+can_filter_pkg::msel_lo +: can_filter_pkg::msel_w]
                : 2'h0;
            assign nxt_fsel[g*5 +: 5] = nxt_active[g] ?
                lanes_all[g*8+can_filter_pkg::fsel_lo +: can_filter_pkg::fsel_w]
                : 5'h00;
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata_ff <= can_filter_pkg::read_zero;
            pslverr_ff <= 1'b0;
            pready_ff <= 1'b1;
            active_ff <= 8'h00;
            msel_ff <= 16'h0000;
            fsel_ff <= 40'h00_0000_0000;
        end
        else
        begin
            if (setup)
            begin
                prdata_ff <= pwrite ? can_filter_pkg::read_zero : rd_mux;
                pslverr_ff <= !mapped || (pwrite && hit_v);
            end
            // Never stalls, but kept in a flop so every output is registered
            pready_ff <= 1'b1;
            active_ff <= nxt_active;
            msel_ff <= nxt_msel;
            fsel_ff <= nxt_fsel;
        end
    end

    // Read data is latched in setup, so access completes in one cycle
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign filter_active = active_ff;
    assign acceptance_mask_select = msel_ff;
    assign target_fifo_select = fsel_ff;
endmodule

// ==== dv/filter_config_assertions.sv ====
// Purpose: Lane checks at the ports
// Assumes: Zero-wait APB; outputs move two edges after a write
// Notes: The lock is watched through the fifo field only
`timescale 1ns/10ps
module filter_config_assertions (input wire logic clk, rst_b, penable,
    pwrite, input wire logic [3:0] pstrb, input wire logic [7:0] paddr,
    filter_active, input wire logic [31:0] pwdata,
    input wire logic [15:0] acceptance_mask_select,
    input wire logic [39:0] target_fifo_select);
    wire w0 = penable && pwrite && paddr == 8'h00;
    wire w4 = penable && pwrite && paddr == 8'h04;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_en_top: assert property (w0 && pstrb[3] |-> ##2
        filter_active[3] == $past(pwdata[31], 2)) else $error("en");
    a_en_ten: assert property (w0 && pstrb[2] |-> ##2
        filter_active[2] == $past(pwdata[23], 2)) else $error("en");
    a_en_twenty: assert property (w4 && pstrb[0] |-> ##2
        filter_active[4] == $past(pwdata[7], 2)) else $error("en");
    a_sel_lock: assert property (w0 && pstrb[0] && pwdata[7] &&
        filter_active[0] |-> ##2 target_fifo_select[4:0] ==
        $past(target_fifo_select[4:0], 2)) else $error("lock");
    a_mask_load: assert property (w0 && pstrb[1] && pwdata[15] &&
        !filter_active[1] |-> ##2 acceptance_mask_select[3:2] ==
        $past(pwdata[14:13], 2)) else $error("mask");
    a_fifo_load: assert property (w4 && pstrb[3] && pwdata[31] &&
        !filter_active[7] |-> ##2 target_fifo_select[39:35] ==
        $past(pwdata[28:24], 2)) else $error("fifo");
    a_off_zero: assert property (!filter_active[5] |->
        acceptance_mask_select[11:10] == 0) else $error("off");
    a_reset_clear: assert property ($rose(rst_b) |->
        filter_active == 0) else $error("reset");
endmodule
bind can_acceptance_filter_config filter_config_assertions i_chk (.*);

// ==== dv/can_acceptance_filter_config_bench.sv ====
// Purpose: Random register traffic against a lane model
// Assumes: Zero-wait APB; prdata holds after the access
// Notes: The view at 0x08 is written (expecting pslverr) and read back against the model
`timescale 1ns/10ps
module can_acceptance_filter_config_bench;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready;
    logic pslverr;
    logic [7:0] paddr = 0, filter_active, a, v, act, m[8];
    logic [31:0] pwdata = 0, prdata, x = 32'hbab7;
    logic [3:0] pstrb = 0;
    logic [15:0] acceptance_mask_select;
    logic [39:0] target_fifo_select;
    int mismatches = 0, checks_done = 0, j;
    always #10 clk = ~clk;
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        r = r ^ (r << 5);
        return r;
    endfunction
    can_acceptance_filter_config i_can_acceptance_filter_config (.*);
    task chk(input logic [39:0] s, w);
        checks_done++;
        if (s !== w) mismatches++;
        if (s !== w) $display("MISMATCH %0t %h", $time, s);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task apb(input logic w);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= x;
        pstrb <= x[7:4] & {4{w}};
        @(posedge clk) penable <= 1;
        do @(posedge clk); while (pready !== 1);
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1;
        m = '{default: 8'h00};
        repeat (300) begin
            @(posedge clk);
            x = xorshift(x);
            a = {4'h0, x[9:8], 2'b00};
            apb(1);
            chk(pslverr, a[3]);
            for (int k = 0; k < 4; k++) begin
                j = a[2] * 4 + k;
                // Lock uses the stored enable, so enable alone still moves
                if (pstrb[k] && !a[3]) m[j] = m[j][7] ?
                    {x[8*k+7], m[j][6:0]} : x[8*k+:8];
            end
            @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                v = m[i][7] ? m[i] : 8'h00;
                act[i] = m[i][7];
                chk(filter_active[i], v[7]);
                chk(acceptance_mask_select[2*i+:2], v[6:5]);
                chk(target_fifo_select[5*i+:5], v[4:0]);
            end
            j = a[2] * 4;
            apb(0);
            if (!a[3]) chk(prdata, {m[j+3], m[j+2], m[j+1], m[j]});
            if (a == 8'h08) chk(prdata, {24'h00_0000, act});
            chk(pslverr, a == 8'h0c);
        end
        $display("random test done");
        rst_b <= 0;
        @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        chk(filter_active, 8'h00);
        chk(target_fifo_select, 40'h00_0000_0000);
        a = 8'h00;
        apb(0);
        chk(prdata, 32'h0000_0000);
        $display("reset test done");
        end_of_test;
    end
    initial begin #100000; mismatches++; end_of_test; end
endmodule
